// ### rtl/energy_accum_pkg.sv
// Shared constants for the energy accumulation configuration block.
package energy_accum_pkg;
  localparam int ADDR_W  = 12;
  localparam int DATA_W  = 32;
  localparam int REG_W   = 16;
  localparam int TOTAL_W = 32;
  localparam int CNT_W   = 16;
  localparam int PHASES  = 3;
  localparam int IRQ_W   = 2;

  // Byte addresses of the registers.
  localparam logic [ADDR_W-1:0] OFF_EP_CONFIG   = 12'h4b0;
  localparam logic [ADDR_W-1:0] OFF_CORE_CONFIG = 12'h500;
  localparam logic [ADDR_W-1:0] OFF_CONTROL     = 12'h504;
  localparam logic [ADDR_W-1:0] OFF_PERIOD      = 12'h508;
  localparam logic [ADDR_W-1:0] OFF_STATUS      = 12'h50c;
  localparam logic [ADDR_W-1:0] OFF_MASK        = 12'h510;
  localparam logic [ADDR_W-1:0] OFF_STATE       = 12'h514;
  localparam logic [ADDR_W-1:0] OFF_WATT        = 12'h520;
  localparam logic [ADDR_W-1:0] OFF_VA          = 12'h524;
  localparam logic [ADDR_W-1:0] OFF_VAR         = 12'h528;
  localparam logic [ADDR_W-1:0] OFF_FVAR        = 12'h52c;

  // Energy and power configuration fields.
  localparam int               EP_NOLOAD_LSB = 13;
  localparam int               EP_SIGN_BIT   = 7;
  localparam int               EP_RDCLR_BIT  = 5;
  localparam int               EP_LOAD_BIT   = 4;
  localparam int               EP_PMODE_BIT  = 1;
  localparam int               EP_EN_BIT     = 0;
  localparam logic [REG_W-1:0] EP_WRITE_MASK = 16'he0b3;
  localparam logic [REG_W-1:0] EP_RESET      = 16'h0000;

  // Core configuration: high-pass corner select field.
  localparam int               CORE_CRN_LSB    = 9;
  localparam logic [REG_W-1:0] CORE_WRITE_MASK = 16'h0e00;
  localparam logic [REG_W-1:0] CORE_RESET      = 16'h0c00;

  // Control register fields.
  localparam int               CTRL_RUN_BIT    = 0;
  localparam int               CTRL_HPDIS_BIT  = 1;
  localparam logic [1:0]       CTRL_RESET      = 2'h0;
  localparam logic [CNT_W-1:0] PERIOD_RESET    = 16'h0000;

  // Interrupt status bits.
  localparam int               IRQ_EGY_RDY = 0;
  localparam int               IRQ_NOLOAD  = 1;

  // No-load window: code 7 turns the check off, else 64 samples shifted by the code.
  localparam logic [2:0]       NOLOAD_OFF_CODE = 3'h7;
  localparam logic [CNT_W-1:0] NOLOAD_BASE     = 16'h0040;
endpackage

// ### rtl/accum_ctl_if.sv
// Control bundle from the register bank to each energy channel.
`timescale 1ns/100ps
interface accum_ctl_if;
  logic run;
  logic sample;
  logic load;
  logic overwrite;

  modport src (output run, output sample, output load, output overwrite);
  modport dst (input run, input sample, input load, input overwrite);
endinterface // accum_ctl_if

// ### rtl/energy_channel.sv
// One energy channel: internal accumulator and user-visible total.
`timescale 1ns/100ps
module energy_channel
  import energy_accum_pkg::*;
(
  input  wire logic                                  i_clk,
  input  wire logic                                  i_rst,
  accum_ctl_if.dst                                   ctl,
  input  wire logic signed [energy_accum_pkg::TOTAL_W-1:0] i_inc,
  input  wire logic                                  i_read_clear,
  output logic signed [energy_accum_pkg::TOTAL_W-1:0] o_total
);
  logic signed [TOTAL_W-1:0] acc_reg;
  logic signed [TOTAL_W-1:0] acc_next;
  logic signed [TOTAL_W-1:0] total_reg;
  logic signed [TOTAL_W-1:0] total_next;
  logic signed [TOTAL_W-1:0] step;
  logic signed [TOTAL_W-1:0] base;

  always_comb begin
    step = (ctl.run && ctl.sample) ? i_inc : '0;
    base = i_read_clear ? '0 : total_reg;
    acc_next   = acc_reg + step;
    total_next = base;
    if (ctl.load) begin
      acc_next = step;
      if (ctl.overwrite) begin
        total_next = acc_reg;
      end else begin
        total_next = base + acc_reg;
      end
    end
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      acc_reg   <= '0;
      total_reg <= '0;
    end else begin
      acc_reg   <= acc_next;
      total_reg <= total_next;
    end
  end

  assign o_total = total_reg;
endmodule // energy_channel

// ### rtl/event_window.sv
// Event counter that pulses when a programmed number of events has passed.
`timescale 1ns/100ps
module event_window
  import energy_accum_pkg::*;
(
  input  wire logic                                i_clk,
  input  wire logic                                i_rst,
  input  wire logic                                i_hold,
  input  wire logic                                i_event,
  input  wire logic [energy_accum_pkg::CNT_W-1:0]  i_limit,
  output logic                                     o_done
);
  logic [CNT_W-1:0] cnt_reg;
  logic [CNT_W-1:0] cnt_next;
  logic [CNT_W-1:0] cnt_inc;
  logic             done_next;

  always_comb begin
    cnt_inc   = cnt_reg + 16'h0001;
    cnt_next  = cnt_reg;
    done_next = 1'b0;
    if (i_hold) begin
      cnt_next = '0;
    end else if (i_event) begin
      if (cnt_inc >= i_limit) begin
        cnt_next  = '0;
        done_next = 1'b1;
      end else begin
        cnt_next = cnt_inc;
      end
    end
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      cnt_reg <= '0;
      o_done  <= 1'b0;
    end else begin
      cnt_reg <= cnt_next;
      o_done  <= done_next;
    end
  end
endmodule // event_window

// ### rtl/energy_accum_config.sv
// Register bank and control logic of the energy accumulation path.
//
// Implementation choice: the APB register port.
`timescale 1ns/100ps
// Operation
// - Three-bit high-pass corner, reset six, when enabled.
// - No-load window selects 64 to 4096 samples.
// - No-load code 111 disables the check entirely.
// - Reverse reactive flag follows total or fundamental.
// - Clear-on-read zeroes an energy total when read.
// - Load mode clear adds accumulator into total.
// - Load mode set overwrites total with accumulator.
// - Period counts samples or zero crossings.
// - Accumulator runs only with enable and run.
module energy_accum_config
  import energy_accum_pkg::*;
(
  input  wire logic                                   I_CLK_SYS,
  input  wire logic                                   I_RST,
  input  wire logic                                   I_PSEL,
  input  wire logic                                   I_PENABLE,
  input  wire logic                                   I_PWRITE,
  input  wire logic [energy_accum_pkg::ADDR_W-1:0]    I_PADDR,
  input  wire logic [energy_accum_pkg::DATA_W-1:0]    I_PWDATA,
  output logic      [energy_accum_pkg::DATA_W-1:0]    O_PRDATA,
  output logic                                        O_PREADY,
  output logic                                        O_PSLVERR,
  input  wire logic                                   I_SAMPLE_STROBE,
  input  wire logic                                   I_ZERO_CROSS,
  input  wire logic signed [energy_accum_pkg::TOTAL_W-1:0] I_WATT_INC,
  input  wire logic signed [energy_accum_pkg::TOTAL_W-1:0] I_VA_INC,
  input  wire logic signed [energy_accum_pkg::TOTAL_W-1:0] I_VAR_INC,
  input  wire logic signed [energy_accum_pkg::TOTAL_W-1:0] I_FVAR_INC,
  input  wire logic [energy_accum_pkg::PHASES-1:0]    I_TOTAL_VAR_NEG,
  input  wire logic [energy_accum_pkg::PHASES-1:0]    I_FUND_VAR_NEG,
  input  wire logic                                   I_BELOW_NOLOAD,
  output logic [energy_accum_pkg::PHASES-1:0]         O_REVERSE_REACTIVE_FLAG,
  output logic                                        O_NOLOAD,
  output logic [2:0]                                  O_HIGHPASS_CORNER_SEL,
  output logic                                        O_HIGHPASS_ENABLE,
  output logic                                        O_ENERGY_READY_EVENT,
  output logic                                        O_IRQ
);
  import energy_accum_pkg::*;

  logic [REG_W-1:0]   energy_power_config_reg;
  logic [REG_W-1:0]   energy_power_config_next;
  logic [REG_W-1:0]   core_cfg_reg;
  logic [REG_W-1:0]   core_cfg_next;
  logic [1:0]         ctrl_reg;
  logic [1:0]         ctrl_next;
  logic [CNT_W-1:0]   period_reg;
  logic [CNT_W-1:0]   period_next;
  logic [IRQ_W-1:0]   status_reg;
  logic [IRQ_W-1:0]   status_next;
  logic [IRQ_W-1:0]   mask_reg;
  logic [IRQ_W-1:0]   mask_next;
  logic               ready_reg;
  logic               ready_next;
  logic [DATA_W-1:0]  rdata_reg;
  logic [DATA_W-1:0]  rdata_next;
  logic               slverr_reg;
  logic               slverr_next;
  logic               access;
  logic               commit;
  logic               wr_commit;
  logic               rd_commit;
  logic               mapped;
  logic [DATA_W-1:0]  rd_mux;

  logic [PHASES-1:0]  rev_reg;
  logic [PHASES-1:0]  rev_next;
  logic               noload_reg;
  logic               noload_next;
  logic               all_below_reg;
  logic               all_below_next;

  logic               run;
  logic               period_event;
  logic               period_done;
  logic               noload_off;
  logic [2:0]         noload_code;
  logic [CNT_W-1:0]   noload_limit;
  logic               noload_done;
  logic [3:0]         read_clear;
  logic signed [TOTAL_W-1:0] totals [4];
  logic signed [TOTAL_W-1:0] incs   [4];
  logic [IRQ_W-1:0]   irq_events;

  accum_ctl_if ctl ();

  // Bus handshake: one wait state gives the read data a flip-flop stage.
  assign access    = I_PSEL && I_PENABLE;
  assign commit    = access && ready_reg;
  assign wr_commit = commit && I_PWRITE;
  assign rd_commit = commit && !I_PWRITE;

  // Unmapped addresses answer with an error and read as zero.
  always_comb begin
    mapped = 1'b1;
    rd_mux = '0;
    unique case (I_PADDR)
      OFF_EP_CONFIG:   rd_mux[REG_W-1:0] = energy_power_config_reg & EP_WRITE_MASK;
      OFF_CORE_CONFIG: rd_mux[REG_W-1:0] = core_cfg_reg & CORE_WRITE_MASK;
      OFF_CONTROL:     rd_mux[1:0] = ctrl_reg;
      OFF_PERIOD:      rd_mux[CNT_W-1:0] = period_reg;
      OFF_STATUS:      rd_mux[IRQ_W-1:0] = status_reg;
      OFF_MASK:        rd_mux[IRQ_W-1:0] = mask_reg;
      OFF_STATE:       rd_mux[PHASES:0] = {noload_reg, rev_reg};
      OFF_WATT:        rd_mux = DATA_W'(totals[0]);
      OFF_VA:          rd_mux = DATA_W'(totals[1]);
      OFF_VAR:         rd_mux = DATA_W'(totals[2]);
      OFF_FVAR:        rd_mux = DATA_W'(totals[3]);
      default:         mapped = 1'b0;
    endcase
  end

  always_comb begin
    ready_next  = access && !ready_reg;
    rdata_next  = rdata_reg;
    slverr_next = 1'b0;
    if (access && !ready_reg) begin
      rdata_next  = I_PWRITE ? '0 : rd_mux;
      slverr_next = !mapped;
    end
  end

  always_ff @(posedge I_CLK_SYS or posedge I_RST) begin
    if (I_RST) begin
      ready_reg  <= 1'b0;
      rdata_reg  <= '0;
      slverr_reg <= 1'b0;
    end else begin
      ready_reg  <= ready_next;
      rdata_reg  <= rdata_next;
      slverr_reg <= slverr_next;
    end
  end

  // Read data holds until the next transfer (a write loads zero), so a slow master still finds it.
  assign O_PREADY  = ready_reg;
  assign O_PRDATA  = rdata_reg;
  assign O_PSLVERR = slverr_reg;

  // Configuration registers; reserved bits are masked on write.
  always_comb begin
    energy_power_config_next   = energy_power_config_reg;
    core_cfg_next = core_cfg_reg;
    ctrl_next     = ctrl_reg;
    period_next   = period_reg;
    mask_next     = mask_reg;
    if (wr_commit) begin
      unique case (I_PADDR)
        OFF_EP_CONFIG:   energy_power_config_next = I_PWDATA[REG_W-1:0] & EP_WRITE_MASK;
        OFF_CORE_CONFIG: core_cfg_next = I_PWDATA[REG_W-1:0] & CORE_WRITE_MASK;
        OFF_CONTROL:     ctrl_next = I_PWDATA[1:0];
        OFF_PERIOD:      period_next = I_PWDATA[CNT_W-1:0];
        OFF_MASK:        mask_next = I_PWDATA[IRQ_W-1:0];
        default:         ;
      endcase
    end
  end

  // Accumulation resets off until software asks for it, but the high-pass filter starts enabled and the no-load check runs from reset.
  always_ff @(posedge I_CLK_SYS or posedge I_RST) begin
    if (I_RST) begin
      energy_power_config_reg   <= EP_RESET;
      core_cfg_reg <= CORE_RESET;
      ctrl_reg     <= CTRL_RESET;
      period_reg   <= PERIOD_RESET;
      mask_reg     <= '0;
    end else begin
      energy_power_config_reg   <= energy_power_config_next;
      core_cfg_reg <= core_cfg_next;
      ctrl_reg     <= ctrl_next;
      period_reg   <= period_next;
      mask_reg     <= mask_next;
    end
  end

  // The corner select is only meaningful to the filter while it is enabled.
  assign O_HIGHPASS_CORNER_SEL = core_cfg_reg[CORE_CRN_LSB +: 3];
  assign O_HIGHPASS_ENABLE     = !ctrl_reg[CTRL_HPDIS_BIT];

  // Accumulation gating and period timing.
  assign run          = energy_power_config_reg[EP_EN_BIT] && ctrl_reg[CTRL_RUN_BIT];
  assign period_event = energy_power_config_reg[EP_PMODE_BIT] ? I_ZERO_CROSS : I_SAMPLE_STROBE;

  // A period count of zero behaves as one, so every event closes a period.
  event_window u_period (
    .i_clk   (I_CLK_SYS),
    .i_rst   (I_RST),
    .i_hold  (!run),
    .i_event (period_event),
    .i_limit (period_reg),
    .o_done  (period_done)
  );

  // Every channel sees the same gating, so the four totals always load together.
  assign ctl.run       = run;
  assign ctl.sample    = I_SAMPLE_STROBE;
  assign ctl.load      = period_done;
  assign ctl.overwrite = energy_power_config_reg[EP_LOAD_BIT];
  assign O_ENERGY_READY_EVENT = period_done;

  // Increments count only on sample strobes; other cycles add nothing.
  assign incs[0] = I_WATT_INC;
  assign incs[1] = I_VA_INC;
  assign incs[2] = I_VAR_INC;
  assign incs[3] = I_FVAR_INC;

  // A read clears the total only on the edge that completes the transfer.
  always_comb begin
    read_clear = '0;
    if (rd_commit && energy_power_config_reg[EP_RDCLR_BIT]) begin
      read_clear[0] = (I_PADDR == OFF_WATT);
      read_clear[1] = (I_PADDR == OFF_VA);
      read_clear[2] = (I_PADDR == OFF_VAR);
      read_clear[3] = (I_PADDR == OFF_FVAR);
    end
  end

  for (genvar g = 0; g < 4; g++) begin : g_chan
    energy_channel u_chan (
      .i_clk        (I_CLK_SYS),
      .i_rst        (I_RST),
      .ctl          (ctl.dst),
      .i_inc        (incs[g]),
      .i_read_clear (read_clear[g]),
      .o_total      (totals[g])
    );
  end

  // No-load window: the flag needs the load below threshold for a whole window.
  assign noload_code  = energy_power_config_reg[EP_NOLOAD_LSB +: 3];
  assign noload_off   = (noload_code == NOLOAD_OFF_CODE);
  assign noload_limit = NOLOAD_BASE << noload_code;

  // Holding the counter while disabled makes a re-enabled window start from zero.
  event_window u_noload (
    .i_clk   (I_CLK_SYS),
    .i_rst   (I_RST),
    .i_hold  (noload_off),
    .i_event (I_SAMPLE_STROBE),
    .i_limit (noload_limit),
    .o_done  (noload_done)
  );

  // The reverse flags are registered, so a sign change reaches the pins one cycle late.
  always_comb begin
    rev_next       = energy_power_config_reg[EP_SIGN_BIT] ? I_FUND_VAR_NEG : I_TOTAL_VAR_NEG;
    all_below_next = all_below_reg;
    noload_next    = noload_reg;
    if (noload_off) begin
      noload_next    = 1'b0;
      all_below_next = 1'b1;
    end else if (noload_done) begin
      noload_next    = all_below_reg;
      // A strobe in the closing cycle already belongs to the next window.
      all_below_next = !(I_SAMPLE_STROBE && !I_BELOW_NOLOAD);
    end else if (I_SAMPLE_STROBE && !I_BELOW_NOLOAD) begin
      all_below_next = 1'b0;
    end
  end

  always_ff @(posedge I_CLK_SYS or posedge I_RST) begin
    if (I_RST) begin
      rev_reg       <= '0;
      noload_reg    <= 1'b0;
      all_below_reg <= 1'b1;
    end else begin
      rev_reg       <= rev_next;
      noload_reg    <= noload_next;
      all_below_reg <= all_below_next;
    end
  end

  assign O_REVERSE_REACTIVE_FLAG = rev_reg;
  assign O_NOLOAD                = noload_reg;

  // Interrupts: a new event beats a write-one clear in the same cycle.
  always_comb begin
    irq_events              = '0;
    irq_events[IRQ_EGY_RDY] = period_done;
    irq_events[IRQ_NOLOAD]  = noload_next && !noload_reg;
    status_next = status_reg;
    if (wr_commit && (I_PADDR == OFF_STATUS)) begin
      status_next = status_reg & ~I_PWDATA[IRQ_W-1:0];
    end
    status_next = status_next | irq_events;
  end

  always_ff @(posedge I_CLK_SYS or posedge I_RST) begin
    if (I_RST) begin
      status_reg <= '0;
    end else begin
      status_reg <= status_next;
    end
  end

  // The interrupt is a plain level, so software may poll it or take its edge.
  assign O_IRQ = |(status_reg & mask_reg);
endmodule // energy_accum_config

// ### verif/energy_accum_config_assertions.sv
// Port-level checks for the energy accumulation register bank.
`timescale 1ns/100ps
module energy_accum_config_assertions
  import energy_accum_pkg::*;
(
  input wire logic                                  I_CLK_SYS,
  input wire logic                                  I_RST,
  input wire logic                                  I_PSEL,
  input wire logic                                  I_PENABLE,
  input wire logic                                  I_PWRITE,
  input wire logic [energy_accum_pkg::ADDR_W-1:0]   I_PADDR,
  input wire logic [energy_accum_pkg::DATA_W-1:0]   O_PRDATA,
  input wire logic                                  O_PREADY,
  input wire logic                                  O_PSLVERR,
  input wire logic                                  I_SAMPLE_STROBE,
  input wire logic                                  I_ZERO_CROSS,
  input wire logic [energy_accum_pkg::PHASES-1:0]   I_TOTAL_VAR_NEG,
  input wire logic [energy_accum_pkg::PHASES-1:0]   I_FUND_VAR_NEG,
  input wire logic                                  I_BELOW_NOLOAD,
  input wire logic [energy_accum_pkg::PHASES-1:0]   O_REVERSE_REACTIVE_FLAG,
  input wire logic                                  O_NOLOAD,
  input wire logic [2:0]                            O_HIGHPASS_CORNER_SEL,
  input wire logic                                  O_HIGHPASS_ENABLE,
  input wire logic                                  O_ENERGY_READY_EVENT
);
  default clocking cb @(posedge I_CLK_SYS); endclocking
  default disable iff (I_RST);
  logic wr_done;
  assign wr_done = I_PSEL && I_PENABLE && I_PWRITE && O_PREADY;
  sequence setup_s; I_PSEL && !I_PENABLE; endsequence
  sequence access_s; I_PSEL && I_PENABLE && !O_PREADY; endsequence
  apb_wait_state_a: assert property (setup_s ##1 access_s |=> O_PREADY)
    else $error("ready did not follow one wait state");
  ready_one_cycle_a: assert property (O_PREADY |=> !O_PREADY)
    else $error("ready stood longer than one cycle");
  err_with_ready_a: assert property (O_PSLVERR |-> O_PREADY)
    else $error("slave error without ready");
  err_read_zero_a: assert property (O_PSLVERR && !I_PWRITE |-> O_PRDATA == '0)
    else $error("refused read returned data");
  ep_reserved_zero_a: assert property (O_PREADY && !I_PWRITE && I_PADDR == OFF_EP_CONFIG
    |-> (O_PRDATA & ~32'(EP_WRITE_MASK)) == '0)
    else $error("reserved energy config bits read nonzero");
  corner_by_write_a: assert property (!$stable(O_HIGHPASS_CORNER_SEL) |-> $past(wr_done))
    else $error("corner select changed without a write");
  hp_by_write_a: assert property (!$stable(O_HIGHPASS_ENABLE) |-> $past(wr_done))
    else $error("highpass enable changed without a write");
  ready_cause_a: assert property (O_ENERGY_READY_EVENT
    |-> $past(I_SAMPLE_STROBE || I_ZERO_CROSS))
    else $error("energy ready without a period event");
  rev_follow_a: assert property (!$past(I_RST) && $past(I_TOTAL_VAR_NEG) == $past(I_FUND_VAR_NEG)
    |-> O_REVERSE_REACTIVE_FLAG == $past(I_TOTAL_VAR_NEG))
    else $error("reverse flag does not follow sign");
  noload_cause_a: assert property ($rose(O_NOLOAD)
    |-> $past(I_BELOW_NOLOAD) || $past(I_BELOW_NOLOAD, 2))
    else $error("no-load flag rose without low power");
endmodule // energy_accum_config_assertions

bind energy_accum_config energy_accum_config_assertions u_chk (.I_CLK_SYS, .I_RST, .I_PSEL,
  .I_PENABLE, .I_PWRITE, .I_PADDR, .O_PRDATA, .O_PREADY, .O_PSLVERR, .I_SAMPLE_STROBE,
  .I_ZERO_CROSS, .I_TOTAL_VAR_NEG, .I_FUND_VAR_NEG, .I_BELOW_NOLOAD, .O_REVERSE_REACTIVE_FLAG,
  .O_NOLOAD, .O_HIGHPASS_CORNER_SEL, .O_HIGHPASS_ENABLE, .O_ENERGY_READY_EVENT);

// ### verif/energy_accum_config_test.sv
// Self-checking bench for the energy accumulation register bank.
`timescale 1ns/100ps
module energy_accum_config_test;
  import energy_accum_pkg::*;
  logic                      clk = 0, rst = 1, psel = 0, pen = 0, pwr = 0;
  logic                      stb = 0, zx = 0, below = 0, err;
  logic                      pready, pslverr, nl, hpen, rdy, irq;
  logic [ADDR_W-1:0]         addr = '0;
  logic [DATA_W-1:0]         wdata = '0, prdata, rd;
  logic signed [TOTAL_W-1:0] inc [4] = '{default: '0};
  logic signed [TOTAL_W-1:0] acc, tot;
  logic [PHASES-1:0]         tneg = '0, fneg = '0, rev;
  logic [2:0]                crn;
  int                        errors = 0, num_checks = 0, nevt = 0, v;
  int                        kk [4] = '{1, 2, -1, 3};

  always #2.5 clk = ~clk;
  always @(posedge clk) if (rdy === 1'b1) nevt++;

  energy_accum_config DUT (.I_CLK_SYS(clk), .I_RST(rst), .I_PSEL(psel), .I_PENABLE(pen),
    .I_PWRITE(pwr), .I_PADDR(addr), .I_PWDATA(wdata), .O_PRDATA(prdata), .O_PREADY(pready),
    .O_PSLVERR(pslverr), .I_SAMPLE_STROBE(stb), .I_ZERO_CROSS(zx), .I_WATT_INC(inc[0]),
    .I_VA_INC(inc[1]), .I_VAR_INC(inc[2]), .I_FVAR_INC(inc[3]), .I_TOTAL_VAR_NEG(tneg),
    .I_FUND_VAR_NEG(fneg), .I_BELOW_NOLOAD(below), .O_REVERSE_REACTIVE_FLAG(rev),
    .O_NOLOAD(nl), .O_HIGHPASS_CORNER_SEL(crn), .O_HIGHPASS_ENABLE(hpen),
    .O_ENERGY_READY_EVENT(rdy), .O_IRQ(irq));

  // Expected user total after one load, in add or overwrite mode.
  function automatic logic signed [TOTAL_W-1:0] load(input logic signed [TOTAL_W-1:0] old,
                                                     input logic signed [TOTAL_W-1:0] a,
                                                     input logic ovw);
    return ovw ? a : old + a;
  endfunction

  task automatic chk(input string what, input logic [DATA_W-1:0] seen, exp);
    num_checks++;
    if (seen !== exp) begin
      errors++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // The wait loop is bounded so a silent slave shows up as a mismatch, not a hang.
  task automatic apb(input logic w, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    int n;
    n = 0;
    @(posedge clk);
    psel <= 1;
    pwr <= w;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    pen <= 1;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    chk("pready", pready, 1);
    rd = prdata;
    err = pslverr;
    psel <= 0;
    pen <= 0;
    @(negedge clk);
  endtask

  task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    apb(1, a, d);
  endtask

  task automatic rdchk(input string what, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] e);
    apb(0, a, '0);
    chk(what, rd, e);
  endtask

  task automatic pulse(input logic z, input int val);
    @(posedge clk);
    if (z) zx <= 1;
    else stb <= 1;
    foreach (inc[i]) inc[i] <= val * kk[i];
    @(posedge clk);
    zx <= 0;
    stb <= 0;
  endtask

  task automatic totals;
    for (int i = 0; i < 4; i++) begin
      rdchk("total", ADDR_W'(OFF_WATT + 4 * i), kk[i] * tot);
    end
  endtask

  task end_of_test;
    $display("checks %0d errors %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  initial begin
    #50us;
    errors++;
    end_of_test;
  end

  initial begin
    void'($urandom(32'h876f5990));
    repeat (16) @(posedge clk);
    rst <= 0;
    rdchk("ep", OFF_EP_CONFIG, '0);
    rdchk("core", OFF_CORE_CONFIG, 32'h0c00);
    chk("corner", crn, 3'h6);
    chk("hpen", hpen, 1);
    apb(0, 12'h400, '0);
    chk("slverr", err, 1);
    chk("rdata", rd, '0);
    wr(OFF_EP_CONFIG, '1);
    rdchk("ep", OFF_EP_CONFIG, 32'he0b3);
    wr(OFF_EP_CONFIG, '0);
    for (int i = 0; i < 8; i++) begin
      wr(OFF_CORE_CONFIG, 32'hfffff1ff | (i << 9));
      chk("corner", crn, i);
      rdchk("core", OFF_CORE_CONFIG, i << 9);
    end
    wr(OFF_CONTROL, 2);
    chk("hpen", hpen, 0);
    // The window starts at reset with the shortest code, so 64 strobes fill it.
    wr(OFF_CONTROL, 1);
    @(posedge clk);
    below <= 1;
    repeat (64) pulse(0, 0);
    repeat (3) @(posedge clk);
    chk("noload", nl, 1);
    chk("irq", irq, 0);
    rdchk("status", OFF_STATUS, 2);
    wr(OFF_MASK, 3);
    chk("irq", irq, 1);
    wr(OFF_STATUS, 2);
    chk("irq", irq, 0);
    wr(OFF_EP_CONFIG, 32'he000);
    repeat (70) pulse(0, 0);
    chk("noload", nl, 0);
    // Code 1 must need exactly 128 strobes below the threshold.
    wr(OFF_EP_CONFIG, 32'h2000);
    repeat (127) pulse(0, 0);
    repeat (3) @(posedge clk);
    chk("noload", nl, 0);
    pulse(0, 0);
    repeat (3) @(posedge clk);
    chk("noload", nl, 1);
    chk("irq", irq, 1);
    wr(OFF_STATUS, 2);
    below <= 0;
    wr(OFF_PERIOD, 2);
    acc = 0;
    tot = 0;
    repeat (3) pulse(0, $urandom_range(1, 1000));
    wr(OFF_EP_CONFIG, 1);
    wr(OFF_CONTROL, 0);
    repeat (3) pulse(0, 77);
    chk("events", nevt, 0);
    totals();
    wr(OFF_CONTROL, 1);
    for (int m = 0; m < 2; m++) begin
      wr(OFF_EP_CONFIG, 1 | (m << 4));
      repeat (2) begin
        repeat (2) begin
          v = $urandom_range(1, 1000);
          pulse(0, v);
          acc += v;
        end
        tot = load(tot, acc, m[0]);
        acc = 0;
      end
      totals();
    end
    chk("events", nevt, 4);
    rdchk("status", OFF_STATUS, 1);
    chk("irq", irq, 1);
    wr(OFF_STATUS, 1);
    chk("irq", irq, 0);
    wr(OFF_EP_CONFIG, 32'h31);
    totals();
    tot = 0;
    totals();
    wr(OFF_EP_CONFIG, 32'h13);
    repeat (3) begin
      v = $urandom_range(1, 1000);
      pulse(0, v);
      acc += v;
    end
    chk("events", nevt, 4);
    repeat (2) pulse(1, 0);
    repeat (2) @(posedge clk);
    chk("events", nevt, 5);
    tot = acc;
    totals();
    for (int s = 0; s < 3; s++) begin
      wr(OFF_EP_CONFIG, (s % 2) << 7);
      @(posedge clk);
      v = $urandom_range(0, 7);
      tneg <= v[2:0];
      fneg <= (s == 2) ? v[2:0] : ~v[2:0];
      repeat (2) @(posedge clk);
      @(negedge clk);
      chk("reverse", rev, (s % 2) ? fneg : tneg);
    end
    end_of_test;
  end
endmodule // energy_accum_config_test
